/* ttcs_pkg.sv */
/*
 * Shared constants and types for the tone transceiver control and status block.
 * Assumes a single 250 MHz system clock and a four-bit host data path.
 */
package ttcs_pkg;
    localparam int unsigned CLK_NS = 4;
    localparam int unsigned BURST_MS = 51;
    localparam int unsigned CP_BURST_MS = 102;
    localparam int unsigned BURST_CYC_DEF = BURST_MS * 1000000 / CLK_NS;
    localparam int unsigned CP_BURST_CYC_DEF = CP_BURST_MS * 1000000 / CLK_NS;
    localparam int unsigned CNT_W = 25;

    // First control register fields.
    localparam int unsigned FC_TONE_EN = 0;
    localparam int unsigned FC_CP = 1;
    localparam int unsigned FC_IE = 2;
    localparam int unsigned FC_REDIR = 3;
    // Second control register fields.
    localparam int unsigned SC_BURST_OFF = 0;
    localparam int unsigned SC_RX_PWDN = 1;
    localparam int unsigned SC_SINGLE = 2;
    localparam int unsigned SC_COLUMN = 3;
    // Status register fields.
    localparam int unsigned ST_IRQ = 0;
    localparam int unsigned ST_TXE = 1;
    localparam int unsigned ST_RXF = 2;
    localparam int unsigned ST_DSTEER = 3;

    localparam logic [3:0] FC_RESET = 4'h0;
    localparam logic [3:0] SC_RESET = 4'h0;
    localparam logic [3:0] STAT_RESET = 4'h0;

    typedef enum logic [2:0] {
        TTCS_IDLE = 3'h1,
        TTCS_TONE = 3'h2,
        TTCS_PAUSE = 3'h4
    } ttcs_burst_t;

    // Host pins: strobes active low, register select, write data.
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic rs;
        logic [3:0] wdata;
    } ttcs_bus_t;

    localparam ttcs_bus_t BUS_IDLE = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, rs: 1'b0,
                                      wdata: 4'h0};

    typedef struct packed {
        ttcs_bus_t s1;
        ttcs_bus_t s2;
        ttcs_bus_t s3;
        ttcs_bus_t filt;
        logic [3:0] fc;
        logic [3:0] sc;
        logic redirect;
        logic [3:0] stat;
        logic [3:0] rx_data;
        ttcs_burst_t st;
        logic [CNT_W-1:0] cnt;
        logic [3:0] code;
        logic tone_act;
        logic [3:0] rdata;
        logic rdoe;
        logic pin_o;
        logic pin_oe;
    } ttcs_state_t;
endpackage

/* ttcs_top.sv */
/*
 * Control and status logic of a tone signalling transceiver: host register port,
 * two control registers sharing one address, read-to-clear status and burst timing.
 * Assumes the host pins are asynchronous and the receiver events are on sys_clk.
 */
`timescale 1ns/1ps
// Functional notes
// - Second control bit 0 low enables burst mode, high disables it.
// - Each transmit write in burst mode with first control bit 0 high starts a burst then an equal pause.
// - Pause end sets transmit-empty status bit 1 and interrupts if enabled.
// - Call progress mode doubles burst and pause lengths to 102 ms.
// - Burst off: tone lasts while first control bit 0 stays high.
// - Second control bit 1 high powers down both receivers.
// - Second control bit 2 high selects single tone, low dual tone.
// - Single tone: second control bit 3 high column tone, low row tone.
// - Status bit 0 set when bit 1 or 2 set, cleared by status read.
// - Status bit 1 set at pause end, cleared by read or burst off.
// - Status bit 2 set on a new received digit, cleared by status read.
// - Status bit 3 set on tone absence, cleared on valid tone detection.
// - Select low maps transmit/receive data; high maps control/status.
// - Redirect bit sends the next control write to the second register.
// - First control: bit 0 tone out, bit 1 call progress, bit 2 interrupt.
// - With interrupt enabled, the interrupt pin pulls low on received digit or transmit ready, or in call progress mode only while cp_wave is low.
module ttcs_top #(
    parameter int unsigned BURST_CYC = ttcs_pkg::BURST_CYC_DEF,
    parameter int unsigned CP_BURST_CYC = ttcs_pkg::CP_BURST_CYC_DEF
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire ttcs_pkg::ttcs_bus_t host_bus,
    output logic [3:0] host_rdata,
    output logic host_rdata_oe,
    input wire logic rx_digit_valid,
    input wire logic [3:0] rx_digit,
    input wire logic rx_tone_absent,
    input wire logic rx_tone_present,
    input wire logic cp_wave,
    output logic tone_output_enable,
    output logic call_progress_mode_select,
    output logic receiver_power_gate,
    output logic single_tone_select,
    output logic column_tone_select,
    output logic tone_active,
    output logic [3:0] tone_code,
    output logic interrupt_or_tone_pin_o,
    output logic interrupt_or_tone_pin_oe
);
    localparam int CW = ttcs_pkg::CNT_W;

    logic rst_meta_r;
    logic rst_n_r;
    ttcs_pkg::ttcs_state_t q_r;
    ttcs_pkg::ttcs_state_t q_nxt;
    ttcs_pkg::ttcs_bus_t nf;
    logic wr_ev;
    logic rd_ev;

    // Burst and pause share one length, picked by the call progress bit.
    function automatic logic [CW-1:0] burst_last(input logic cp);
        burst_last = cp ? CW'(CP_BURST_CYC - 1) : CW'(BURST_CYC - 1);
    endfunction

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // A pin change is taken only once the second and third stages agree.
    assign nf = (q_r.s2 == q_r.s3) ? q_r.s3 : q_r.filt;
    // Accesses act at the trailing edge of the strobe, while chip select is held.
    assign wr_ev = !q_r.filt.wr_n && nf.wr_n && !q_r.filt.cs_n;
    assign rd_ev = !q_r.filt.rd_n && nf.rd_n && !q_r.filt.cs_n;

    always_comb begin
        logic txe_set;
        logic burst_on;
        txe_set = 1'b0;
        q_nxt = q_r;
        q_nxt.s1 = host_bus;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
        q_nxt.filt = nf;

        if (wr_ev && q_r.filt.rs) begin
            if (q_r.redirect) begin
                q_nxt.sc = q_r.filt.wdata;
                q_nxt.redirect = 1'b0;
            end else begin
                q_nxt.fc = q_r.filt.wdata;
                q_nxt.redirect = q_r.filt.wdata[ttcs_pkg::FC_REDIR];
            end
        end
        burst_on = !q_nxt.sc[ttcs_pkg::SC_BURST_OFF];

        case (q_r.st)
            ttcs_pkg::TTCS_IDLE: begin
                q_nxt.cnt = '0;
            end
            ttcs_pkg::TTCS_TONE: begin
                q_nxt.cnt = q_r.cnt + CW'(1);
                if (q_r.cnt >= burst_last(q_r.fc[ttcs_pkg::FC_CP])) begin
                    q_nxt.st = ttcs_pkg::TTCS_PAUSE;
                    q_nxt.cnt = '0;
                end
            end
            ttcs_pkg::TTCS_PAUSE: begin
                q_nxt.cnt = q_r.cnt + CW'(1);
                if (q_r.cnt >= burst_last(q_r.fc[ttcs_pkg::FC_CP])) begin
                    q_nxt.st = ttcs_pkg::TTCS_IDLE;
                    q_nxt.cnt = '0;
                    txe_set = 1'b1;
                end
            end
            default: begin
                q_nxt.st = ttcs_pkg::TTCS_IDLE;
                q_nxt.cnt = '0;
            end
        endcase

        // A new digit restarts the burst; the host is meant to wait for ready.
        if (wr_ev && !q_r.filt.rs) begin
            q_nxt.code = q_r.filt.wdata;
            if (burst_on) begin
                q_nxt.st = ttcs_pkg::TTCS_TONE;
                q_nxt.cnt = '0;
            end
        end
        if (!burst_on || !q_nxt.fc[ttcs_pkg::FC_TONE_EN]) begin
            q_nxt.st = ttcs_pkg::TTCS_IDLE;
            q_nxt.cnt = '0;
            txe_set = 1'b0;
        end

        if (rx_digit_valid) begin
            q_nxt.rx_data = rx_digit;
        end

        // Flags are cleared after the read so the host sees the old value.
        if (rd_ev && q_r.filt.rs) begin
            q_nxt.stat[ttcs_pkg::ST_IRQ] = 1'b0;
            q_nxt.stat[ttcs_pkg::ST_TXE] = 1'b0;
            q_nxt.stat[ttcs_pkg::ST_RXF] = 1'b0;
        end
        if (txe_set) begin
            q_nxt.stat[ttcs_pkg::ST_TXE] = 1'b1;
        end
        if (!burst_on) begin
            q_nxt.stat[ttcs_pkg::ST_TXE] = 1'b0;
        end
        if (rx_digit_valid) begin
            q_nxt.stat[ttcs_pkg::ST_RXF] = 1'b1;
        end
        if (txe_set || rx_digit_valid) begin
            q_nxt.stat[ttcs_pkg::ST_IRQ] = 1'b1;
        end
        if (rx_tone_present) begin
            q_nxt.stat[ttcs_pkg::ST_DSTEER] = 1'b0;
        end
        if (rx_tone_absent) begin
            q_nxt.stat[ttcs_pkg::ST_DSTEER] = 1'b1;
        end

        if (burst_on) begin
            q_nxt.tone_act = q_nxt.st == ttcs_pkg::TTCS_TONE;
        end else begin
            q_nxt.tone_act = q_nxt.fc[ttcs_pkg::FC_TONE_EN];
        end

        q_nxt.rdoe = !nf.cs_n && !nf.rd_n;
        q_nxt.rdata = nf.rs ? q_r.stat : q_r.rx_data;
        q_nxt.pin_o = 1'b0;
        if (!q_nxt.fc[ttcs_pkg::FC_IE]) begin
            q_nxt.pin_oe = 1'b0;
        end else if (q_nxt.fc[ttcs_pkg::FC_CP]) begin
            q_nxt.pin_oe = !cp_wave;
        end else begin
            q_nxt.pin_oe = q_nxt.stat[ttcs_pkg::ST_IRQ];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            q_r.s1 <= ttcs_pkg::BUS_IDLE;
            q_r.s2 <= ttcs_pkg::BUS_IDLE;
            q_r.s3 <= ttcs_pkg::BUS_IDLE;
            q_r.filt <= ttcs_pkg::BUS_IDLE;
            q_r.fc <= ttcs_pkg::FC_RESET;
            q_r.sc <= ttcs_pkg::SC_RESET;
            q_r.redirect <= 1'b0;
            q_r.stat <= ttcs_pkg::STAT_RESET;
            q_r.rx_data <= 4'h0;
            q_r.st <= ttcs_pkg::TTCS_IDLE;
            q_r.cnt <= '0;
            q_r.code <= 4'h0;
            q_r.tone_act <= 1'b0;
            q_r.rdata <= 4'h0;
            q_r.rdoe <= 1'b0;
            q_r.pin_o <= 1'b0;
            q_r.pin_oe <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign host_rdata = q_r.rdata;
    assign host_rdata_oe = q_r.rdoe;
    assign tone_output_enable = q_r.fc[ttcs_pkg::FC_TONE_EN];
    assign call_progress_mode_select = q_r.fc[ttcs_pkg::FC_CP];
    assign receiver_power_gate = q_r.sc[ttcs_pkg::SC_RX_PWDN];
    assign single_tone_select = q_r.sc[ttcs_pkg::SC_SINGLE];
    assign column_tone_select = q_r.sc[ttcs_pkg::SC_COLUMN];
    assign tone_active = q_r.tone_act;
    assign tone_code = q_r.code;
    assign interrupt_or_tone_pin_o = q_r.pin_o;
    assign interrupt_or_tone_pin_oe = q_r.pin_oe;

    a_burst_off_txe: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        q_r.sc[ttcs_pkg::SC_BURST_OFF] |-> !q_r.stat[ttcs_pkg::ST_TXE])
        else $error("transmit empty set while burst mode off");
    a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (q_r.stat[ttcs_pkg::ST_TXE] || q_r.stat[ttcs_pkg::ST_RXF]) |-> q_r.stat[ttcs_pkg::ST_IRQ])
        else $error("interrupt status missing while a cause is set");
    a_tone_to_pause: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        q_r.st == ttcs_pkg::TTCS_TONE && q_r.cnt == burst_last(q_r.fc[ttcs_pkg::FC_CP])
        && !wr_ev && q_r.sc == $past(q_r.sc) |=> q_r.st != ttcs_pkg::TTCS_TONE)
        else $error("burst did not end on time");
    a_pause_end_txe: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        q_r.st == ttcs_pkg::TTCS_PAUSE && q_r.cnt == burst_last(q_r.fc[ttcs_pkg::FC_CP])
        && !wr_ev |=> q_r.stat[ttcs_pkg::ST_TXE] && q_r.stat[ttcs_pkg::ST_IRQ])
        else $error("pause end did not set transmit empty");
    a_redirect_use: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        wr_ev && q_r.filt.rs && q_r.redirect |=> !q_r.redirect && q_r.sc == $past(q_r.filt.wdata))
        else $error("redirected write missed second control register");
    a_rx_full: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        rx_digit_valid |=> q_r.stat[ttcs_pkg::ST_RXF] && q_r.rx_data == $past(rx_digit))
        else $error("received digit not flagged");
    a_steer_clear: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        rx_tone_present && !rx_tone_absent |=> !q_r.stat[ttcs_pkg::ST_DSTEER])
        else $error("delayed steering not cleared");
    a_level_tone: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        q_r.sc[ttcs_pkg::SC_BURST_OFF] |-> q_r.tone_act == q_r.fc[ttcs_pkg::FC_TONE_EN])
        else $error("tone does not follow tone enable");
    a_read_clear: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        rd_ev && q_r.filt.rs && !rx_digit_valid && q_r.st != ttcs_pkg::TTCS_PAUSE
        |=> !q_r.stat[ttcs_pkg::ST_IRQ])
        else $error("status read did not clear interrupt flag");
    a_pin_irq: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        q_r.fc[ttcs_pkg::FC_IE] && !q_r.fc[ttcs_pkg::FC_CP]
        |-> q_r.pin_oe == q_r.stat[ttcs_pkg::ST_IRQ])
        else $error("interrupt pin does not match status");
endmodule

/* ttcs_host_model.sv */
/*
 * Host microcontroller model that drives the register port pins.
 * Assumes one system clock; pins change only on its falling edges.
 */
`timescale 1ns/1ps
module ttcs_host_model (
    input wire logic sys_clk,
    output ttcs_pkg::ttcs_bus_t host_bus
);
    initial host_bus = ttcs_pkg::BUS_IDLE;

    // Strobes are held long enough for the pin synchronisers and the glitch filter.
    task automatic access(input logic rs, input logic wr, input logic [3:0] d);
        @(negedge sys_clk);
        host_bus.cs_n = 1'b0;
        host_bus.rs = rs;
        host_bus.wdata = d;
        @(negedge sys_clk);
        if (wr) begin
            host_bus.wr_n = 1'b0;
        end else begin
            host_bus.rd_n = 1'b0;
        end
        repeat (8) @(negedge sys_clk);
        host_bus.wr_n = 1'b1;
        host_bus.rd_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        host_bus.cs_n = 1'b1;
        // A released data bus must not keep showing the last value.
        host_bus.wdata = ~d;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule

/* ttcs_top_test.sv */
/*
 * Self-checking bench for the tone transceiver control and status block.
 * Assumes short burst counts and a host model that owns the register pins.
 */
`timescale 1ns/1ps
module ttcs_top_test;
    localparam int unsigned BC = 20;
    localparam int unsigned CPC = 40;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    ttcs_pkg::ttcs_bus_t host_bus;
    logic [3:0] host_rdata;
    logic host_rdata_oe;
    logic rx_digit_valid = 1'b0;
    logic [3:0] rx_digit = 4'h0;
    logic rx_tone_absent = 1'b0;
    logic rx_tone_present = 1'b0;
    logic cp_wave = 1'b1;
    logic tone_output_enable, call_progress_mode_select, receiver_power_gate;
    logic single_tone_select, column_tone_select, tone_active;
    logic [3:0] tone_code;
    logic pin_o, pin_oe, oe_q = 1'b0;
    logic [15:0] rnd = 16'hA520;
    logic [3:0] exp_q[$];
    int errors = 0;
    int checks_done = 0;
    int hi, gap;

    always #2 sys_clk = ~sys_clk;

    ttcs_host_model u_host (.sys_clk(sys_clk), .host_bus(host_bus));
    ttcs_top #(.BURST_CYC(BC), .CP_BURST_CYC(CPC)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .host_bus(host_bus), .host_rdata(host_rdata),
        .host_rdata_oe(host_rdata_oe), .rx_digit_valid(rx_digit_valid), .rx_digit(rx_digit),
        .rx_tone_absent(rx_tone_absent), .rx_tone_present(rx_tone_present), .cp_wave(cp_wave),
        .tone_output_enable(tone_output_enable),
        .call_progress_mode_select(call_progress_mode_select),
        .receiver_power_gate(receiver_power_gate), .single_tone_select(single_tone_select),
        .column_tone_select(column_tone_select), .tone_active(tone_active),
        .tone_code(tone_code), .interrupt_or_tone_pin_o(pin_o),
        .interrupt_or_tone_pin_oe(pin_oe));

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic rs, input logic [3:0] d);
        u_host.access(rs, 1'b1, d);
    endtask

    task automatic rd(input logic rs, input logic [3:0] want);
        exp_q.push_back(want);
        u_host.access(rs, 1'b0, 4'h0);
    endtask

    // Measures tone length, then the wait from tone end to the interrupt pin.
    task automatic burst_len();
        hi = 0;
        gap = 0;
        while (tone_active !== 1'b1 && gap < 200) begin
            @(negedge sys_clk);
            gap++;
        end
        while (tone_active === 1'b1 && hi < 200) begin
            @(negedge sys_clk);
            hi++;
        end
        gap = 0;
        while (pin_oe !== 1'b1 && gap < 200) begin
            @(negedge sys_clk);
            gap++;
        end
    endtask

    // Read data is judged on the cycle the output enable first shows.
    always @(negedge sys_clk) begin
        if (host_rdata_oe === 1'b1 && oe_q === 1'b0) begin
            check(host_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 4'hX);
        end
        oe_q = host_rdata_oe;
    end

    initial begin
        #20000;
        errors++;
        conclude();
    end

    initial begin
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (5) @(negedge sys_clk);
        rd(1'b1, 4'h0);
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h8);
        wr(1'b1, 4'h0);
        rd(1'b1, 4'h0);
        check({tone_output_enable, call_progress_mode_select, receiver_power_gate}, 3'h0);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(lfsr(lfsr(rnd)));
            wr(1'b1, {1'b1, 1'b0, rnd[1:0]});
            wr(1'b1, rnd[7:4]);
            check({column_tone_select, single_tone_select, receiver_power_gate}, rnd[7:5]);
            check({call_progress_mode_select, tone_output_enable}, rnd[1:0]);
            wr(1'b1, {2'h0, rnd[9:8]});
            check({call_progress_mode_select, tone_output_enable}, rnd[9:8]);
            check({column_tone_select, single_tone_select}, rnd[7:6]);
        end
        wr(1'b1, 4'hD);
        wr(1'b1, 4'h0);
        fork
            u_host.access(1'b0, 1'b1, 4'h7);
            burst_len();
        join
        check(hi, BC);
        check(gap >= BC && gap <= BC + 2, 1'b1);
        check(tone_code, 4'h7);
        rd(1'b1, 4'h3);
        rd(1'b1, 4'h0);
        check(pin_oe, 1'b0);
        wr(1'b1, 4'h3);
        fork
            u_host.access(1'b0, 1'b1, 4'h5);
            burst_len();
        join
        check(hi, CPC);
        rd(1'b1, 4'h3);
        wr(1'b1, 4'h6);
        cp_wave = 1'b0;
        repeat (6) @(negedge sys_clk);
        check(pin_oe, 1'b1);
        cp_wave = 1'b1;
        repeat (6) @(negedge sys_clk);
        check(pin_oe, 1'b0);
        wr(1'b1, 4'h9);
        wr(1'b1, 4'h1);
        check(tone_active, 1'b1);
        wr(1'b0, 4'h2);
        repeat (100) @(negedge sys_clk);
        check(tone_active, 1'b1);
        rd(1'b1, 4'h0);
        wr(1'b1, 4'h4);
        check(tone_active, 1'b0);
        rx_digit = rnd[3:0];
        rx_digit_valid = 1'b1;
        rx_tone_absent = 1'b1;
        @(negedge sys_clk);
        rx_digit_valid = 1'b0;
        rx_tone_absent = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(pin_oe, 1'b1);
        check(pin_o, 1'b0);
        rd(1'b1, 4'hD);
        rd(1'b0, rnd[3:0]);
        rx_tone_present = 1'b1;
        @(negedge sys_clk);
        rx_tone_present = 1'b0;
        rd(1'b1, 4'h0);
        check(exp_q.size(), 0);
        conclude();
    end
endmodule
